// [hw/tc2_regs.vh]
// register offsets, field positions, reset values and codes for the
// 16-bit event/window counter; included by the counter top only.
`ifndef COUNTER_REGS_VH
`define COUNTER_REGS_VH
`define OFS_CTRL 8'h00
`define OFS_CMP_LOW 8'h04
`define OFS_CMP_HIGH 8'h08
`define OFS_COUNT 8'h0C
`define OFS_STATUS 8'h10
`define OFS_MASK 8'h14
`define OFS_POWER 8'h18
`define CTRL_MODE_BIT 0
`define CTRL_SRC_LSB 2
`define CTRL_SRC_MSB 4
`define CTRL_RUN_BIT 5
`define PWR_SLOW_TWO_STATE_BIT 0
`define PWR_STOP_BIT 1
`define CMP_RESET 16'hFFFF
`define CTRL_RESET 8'h00
`define SRC_EXT 3'h7
`define SRC_RSVD 3'h6
`define SRC_FC 3'h4
`define SRC_FS 3'h5
`define WARM_MASK 16'hF800
`define SEL_DIV_LOG_0 23
`define SEL_DIV_LOG_1 13
`define SEL_DIV_LOG_2 8
`define SEL_DIV_LOG_3 3
`define FS_DIV_LOG 9
`endif

// [hw/pin_sync.v]
// two-flop synchroniser with edge detection for the external count pin.
// assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire clk,
  input wire rst_b,
  input wire pin_in,
  output reg level_ff,
  output wire rise,
  output wire fall
);
  reg meta_ff;
  reg sync_ff;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      level_ff <= sync_ff;
    end
  end
  assign rise = sync_ff & ~level_ff;
  assign fall = ~sync_ff & level_ff;
endmodule // pin_sync
`default_nettype wire

// [hw/event_window_counter.v]
// 16-bit up counter with timer, event and window modes behind an APB slave.
// assumes one 10 MHz clock; external pin is asynchronous and slow.
`timescale 1ns/1ps
`default_nettype none
`include "tc2_regs.vh"
module event_window_counter #(
  parameter WIDTH = 16,
  parameter PRESC_W = 24
) (
  input wire clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire external_count_pin,
  input wire stop_enter,
  output reg counter_match_interrupt,
  output reg irq_ff
);
  // control, compare and interrupt state
  reg [7:0] ctrl_ff;
  reg [WIDTH-1:0] cmp_ff;
  reg [7:0] low_hold_ff;
  reg low_pend_ff;
  reg [1:0] power_ff;
  reg mask_ff;
  reg status_ff;

  // counter and prescaler
  reg [WIDTH-1:0] count_ff;
  reg [PRESC_W-1:0] presc_ff;
  reg tick_ff;

  // stop request synchroniser
  reg stop_meta_ff;
  reg stop_sync_ff;
  reg stop_old_ff;

  // next values of the registered state
  reg [WIDTH-1:0] nxt_count;
  reg [PRESC_W-1:0] nxt_presc;
  reg nxt_tick;
  reg nxt_status;
  reg [31:0] nxt_rdata;
  reg nxt_err;

  // mode decode
  reg inc;
  reg chk;
  reg match;

  wire pin_level;
  wire pin_rise;
  wire pin_fall;
  wire run;
  wire window_mode;
  wire [2:0] src;
  wire event_mode;
  wire warm;
  wire setup;
  wire wr;
  wire rd;
  wire wr_ctrl;
  wire wr_cmp_low;
  wire wr_cmp_high;
  wire wr_mask;
  wire wr_power;
  wire rd_status;
  wire stop_edge;
  wire [PRESC_W-1:0] tap;
  wire tap_full;
  wire [WIDTH-1:0] count_inc;
  wire [PRESC_W-1:0] presc_inc;

  // mask of n low ones, n not above PRESC_W
  function [PRESC_W-1:0] low_ones;
    input integer n;
    begin
      low_ones = {PRESC_W{1'b1}} >> (PRESC_W - n);
    end
  endfunction

  // prescaler tap for each internal source code
  function [PRESC_W-1:0] sel_mask;
    input [2:0] code;
    begin
      case (code)
        3'h0: sel_mask = low_ones(`SEL_DIV_LOG_0);
        3'h1: sel_mask = low_ones(`SEL_DIV_LOG_1);
        3'h2: sel_mask = low_ones(`SEL_DIV_LOG_2);
        3'h3: sel_mask = low_ones(`SEL_DIV_LOG_3);
        3'h5: sel_mask = low_ones(`FS_DIV_LOG);
        default: sel_mask = {PRESC_W{1'b0}};
      endcase
    end
  endfunction

  // addresses that answer without an error
  function addr_mapped;
    input [7:0] addr;
    begin
      case (addr)
        `OFS_CTRL, `OFS_CMP_LOW, `OFS_CMP_HIGH: addr_mapped = 1'b1;
        `OFS_COUNT, `OFS_STATUS: addr_mapped = 1'b1;
        `OFS_MASK, `OFS_POWER: addr_mapped = 1'b1;
        default: addr_mapped = 1'b0;
      endcase
    end
  endfunction

  // read value of one register, zero elsewhere
  function [31:0] reg_value;
    input [7:0] addr;
    input [7:0] ctrl;
    input [WIDTH-1:0] cmp;
    input [WIDTH-1:0] count;
    input status;
    input mask;
    input [1:0] power;
    begin
      case (addr)
        `OFS_CTRL: reg_value = {24'h000000, ctrl};
        `OFS_CMP_LOW: reg_value = {24'h000000, cmp[7:0]};
        `OFS_CMP_HIGH: reg_value = {{(40-WIDTH){1'b0}}, cmp[WIDTH-1:8]};
        `OFS_COUNT: reg_value = {{(32-WIDTH){1'b0}}, count};
        `OFS_STATUS: reg_value = {31'h00000000, status};
        `OFS_MASK: reg_value = {31'h00000000, mask};
        `OFS_POWER: reg_value = {30'h00000000, power};
        default: reg_value = 32'h00000000;
      endcase
    end
  endfunction

  pin_sync u_pin (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in(external_count_pin),
    .level_ff(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign run = ctrl_ff[`CTRL_RUN_BIT];
  assign window_mode = ctrl_ff[`CTRL_MODE_BIT];
  assign src = ctrl_ff[`CTRL_SRC_MSB:`CTRL_SRC_LSB];
  assign event_mode = src == `SRC_EXT && !window_mode;
  // warm-up: slow-two state with the oscillator source in timer mode
  assign warm = power_ff[`PWR_SLOW_TWO_STATE_BIT] && src == `SRC_FC && !window_mode;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && penable && !pwrite && pready;
  assign wr_ctrl = wr && paddr == `OFS_CTRL;
  assign wr_cmp_low = wr && paddr == `OFS_CMP_LOW;
  assign wr_cmp_high = wr && paddr == `OFS_CMP_HIGH;
  assign wr_mask = wr && paddr == `OFS_MASK;
  assign wr_power = wr && paddr == `OFS_POWER;
  assign rd_status = rd && paddr == `OFS_STATUS;
  assign stop_edge = stop_sync_ff && !stop_old_ff;

  assign tap = sel_mask(src);
  assign tap_full = (presc_ff & tap) == tap;
  assign count_inc = count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
  assign presc_inc = presc_ff + {{(PRESC_W-1){1'b0}}, 1'b1};

  // internal counting clock as a one-cycle enable from the prescaler
  always @* begin
    nxt_presc = {PRESC_W{1'b0}};
    nxt_tick = 1'b0;
    if (run) begin
      nxt_tick = tap_full;
      if (!tap_full)
        nxt_presc = presc_inc;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      presc_ff <= {PRESC_W{1'b0}};
      tick_ff <= 1'b0;
    end else begin
      presc_ff <= nxt_presc;
      tick_ff <= nxt_tick;
    end
  end

  always @* begin
    inc = 1'b0;
    chk = 1'b0;
    if (run && src != `SRC_RSVD) begin
      if (event_mode) begin
        inc = pin_rise;
        chk = pin_fall;
      end else if (window_mode && src != `SRC_EXT) begin
        inc = tick_ff && pin_level;
        chk = inc;
      end else if (!window_mode) begin
        inc = tick_ff;
        chk = inc;
      end
    end
    if (warm)
      match = chk && ((count_inc & `WARM_MASK) == (cmp_ff & `WARM_MASK));
    else if (event_mode)
      match = chk && count_ff == cmp_ff;
    else
      match = chk && count_inc == cmp_ff;
  end

  always @* begin
    nxt_count = count_ff;
    if (!run)
      nxt_count = {WIDTH{1'b0}};
    else if (match)
      nxt_count = {WIDTH{1'b0}};
    else if (inc)
      nxt_count = count_inc;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff <= {WIDTH{1'b0}};
      counter_match_interrupt <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      counter_match_interrupt <= match;
    end
  end

  // stop request synchronised; run bit cleared on entry
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_meta_ff <= 1'b0;
      stop_sync_ff <= 1'b0;
      stop_old_ff <= 1'b0;
    end else begin
      stop_meta_ff <= stop_enter;
      stop_sync_ff <= stop_meta_ff;
      stop_old_ff <= stop_sync_ff;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= `CTRL_RESET;
    end else begin
      if (wr_ctrl)
        ctrl_ff <= pwdata[7:0];
      if (stop_edge)
        ctrl_ff[`CTRL_RUN_BIT] <= 1'b0;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_ff <= 1'b0;
      power_ff <= 2'b00;
    end else begin
      if (wr_mask)
        mask_ff <= pwdata[0];
      if (wr_power)
        power_ff <= pwdata[1:0];
    end
  end

  // compare pair: the high byte commits the held low byte
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_ff <= `CMP_RESET;
      low_hold_ff <= 8'h00;
      low_pend_ff <= 1'b0;
    end else begin
      if (wr_cmp_low) begin
        low_hold_ff <= pwdata[7:0];
        low_pend_ff <= 1'b1;
      end else if (wr_cmp_high) begin
        low_pend_ff <= 1'b0;
        if (low_pend_ff)
          cmp_ff <= {pwdata[WIDTH-9:0], low_hold_ff};
        else if (warm)
          cmp_ff <= {pwdata[WIDTH-9:0], cmp_ff[7:0]};
      end
    end
  end

  // sticky status; set wins over the read clear
  always @* begin
    nxt_status = status_ff;
    if (match)
      nxt_status = 1'b1;
    else if (rd_status)
      nxt_status = 1'b0;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq_ff <= nxt_status && mask_ff;
    end
  end

  // apb: no wait state, pready in the access cycle
  always @* begin
    nxt_rdata = prdata;
    nxt_err = 1'b0;
    if (setup) begin
      nxt_rdata = reg_value(paddr, ctrl_ff, cmp_ff, count_ff, status_ff,
        mask_ff, power_ff);
      nxt_err = !addr_mapped(paddr);
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= nxt_err;
      prdata <= nxt_rdata;
    end
  end
endmodule // event_window_counter
`default_nettype wire

// [verif/event_window_counter_sva.sv]
// assertions on the ports of the event/window counter.
// assumes one clock and an async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module event_window_counter_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stop_enter,
  input wire logic counter_match_interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_ans; s_setup |=> s_access; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_rdy_once; pready |=> !pready; endproperty
  a_rdy_once: assert property (p_rdy_once) else $error("long ready");
  property p_rdy_acc; pready |-> psel && penable; endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("stray ready");
  property p_err; s_setup and paddr > 8'h18 |=> pslverr; endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_ok; s_setup and paddr <= 8'h18 |=> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("false error");
  property p_err_data; pslverr |-> prdata == 32'h0; endproperty
  a_err_data: assert property (p_err_data) else $error("error data");
  property p_pulse; counter_match_interrupt |=> !counter_match_interrupt;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_stop;
    $rose(stop_enter) |-> ##6 !counter_match_interrupt [*8];
  endproperty
  a_stop: assert property (p_stop) else $error("runs in stop");
endmodule // event_window_counter_sva
bind event_window_counter event_window_counter_sva u_sva (.clk(clk),
  .rst_b(rst_b), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stop_enter(stop_enter),
  .counter_match_interrupt(counter_match_interrupt));
`default_nettype wire

// [verif/pin_source.sv]
// model of the external count or gate source on the count pin.
// assumes the caller enters its task just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  input wire logic clk,
  output var logic pin
);
  initial pin = 1'b0;
  // each level held n cycles; callers keep n at 8 or more
  task lvl(input logic v, input int n);
    pin <= v;
    repeat (n) @(posedge clk);
  endtask
endmodule // pin_source
`default_nettype wire

// [verif/tb_event_window_counter.sv]
// self-checking bench for the event/window counter over APB.
// assumes a 10 MHz clock and the pin model driving the count pin.
`timescale 1ns/1ps
`default_nettype none
module tb_event_window_counter;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic stop_enter = 0, pin, cmi, irq_ff, pready, pslverr;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  int miscompares = 0, checked = 0, cyc = 0;
  always #50 clk = ~clk;
  event_window_counter u_event_window_counter (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_pin(pin), .stop_enter(stop_enter),
    .counter_match_interrupt(cmi), .irq_ff(irq_ff));
  pin_source u_pin_source (.clk(clk), .pin(pin));
  task end_sim;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim;
    end
  end
  task chk(input logic ok);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("BAD %0t mismatch", $time);
    end
  endtask
  task apb(input [7:0] a, input w, input [31:0] d, output [31:0] q,
           output e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task rd(input [7:0] a, input [31:0] x);
    logic [31:0] q;
    logic e;
    apb(a, 0, 0, q, e);
    chk(q === x && e === (a > 8'h18));
  endtask
  task wr(input [7:0] a, input [31:0] d);
    logic [31:0] q;
    logic e;
    apb(a, 1, d, q, e);
    chk(e === (a > 8'h18));
  endtask
  task per(input int x);
    int n;
    n = 0;
    while (cmi !== 1'b1 && n < 5000) begin @(negedge clk); n++; end
    n = 0;
    do begin @(negedge clk); n++; end while (cmi !== 1'b1 && n < 5000);
    chk(n === x);
    @(posedge clk);
  endtask
  task irqchk(input logic x);
    @(negedge clk);
    chk(irq_ff === x);
    @(posedge clk);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    rd(8'h00, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h1C, 32'h0);
    wr(8'h1C, 32'h1);
    wr(8'h14, 32'h1);
    wr(8'h04, 32'h5);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h30);
    per(5);
    wr(8'h00, 32'h0);
    irqchk(1);
    rd(8'h10, 32'h1);
    rd(8'h10, 32'h0);
    irqchk(0);
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h30);
    per(5);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h30);
    per(3);
    stop_enter <= 1;
    repeat (6) @(posedge clk);
    rd(8'h00, 32'h10);
    rd(8'h0C, 32'h0);
    stop_enter <= 0;
    wr(8'h00, 32'h38);
    repeat (40) @(posedge clk);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h1);
    wr(8'h00, 32'h3C);
    repeat (2) begin
      u_pin_source.lvl(1, 10);
      u_pin_source.lvl(0, 10);
    end
    u_pin_source.lvl(1, 10);
    rd(8'h0C, 32'h3);
    rd(8'h10, 32'h0);
    u_pin_source.lvl(0, 10);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h1);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h32);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h31);
    u_pin_source.lvl(0, 100);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h0);
    u_pin_source.lvl(1, 60);
    u_pin_source.lvl(0, 10);
    rd(8'h10, 32'h1);
    wr(8'h00, 32'h10);
    wr(8'h18, 32'h1);
    wr(8'h08, 32'h8);
    wr(8'h00, 32'h30);
    per(2048);
    end_sim;
  end
endmodule // tb_event_window_counter
`default_nettype wire
